// >>> verilog/fmdc_params.svh
`ifndef FMDC_PARAMS_SVH
`define FMDC_PARAMS_SVH

// Register offsets on the plain register port.
`define FMDC_OFF_STATUS 8'h00
`define FMDC_OFF_CONFIG 8'h04
`define FMDC_OFF_INDEX 8'h08
`define FMDC_OFF_WORD 8'h0c
`define FMDC_OFF_MARGIN 8'h10
`define FMDC_OFF_PROTECT 8'h14

// Status register bit positions.
`define FMDC_BIT_COMMAND_COMPLETE_FLAG 7
`define FMDC_BIT_ACCESS_ERROR_FLAG 5
`define FMDC_BIT_PROTECTION_VIOLATION_FLAG 4
`define FMDC_BIT_MG1 1
`define FMDC_BIT_MG0 0

// Configuration register bit positions.
`define FMDC_BIT_COMMAND_COMPLETE_IRQ_ENABLE 7
`define FMDC_BIT_PROT_EN 0

// Command opcodes.
`define FMDC_CMD_FIELD_MARGIN 8'h0e
`define FMDC_CMD_ERASE_VERIFY 8'h10
`define FMDC_CMD_PROGRAM 8'h11

// Margin level codes.
`define FMDC_MARGIN_NORMAL 16'h0000
`define FMDC_MARGIN_USER_ERASED 16'h0001
`define FMDC_MARGIN_USER_PROG 16'h0002
`define FMDC_MARGIN_FIELD_ERASED 16'h0003
`define FMDC_MARGIN_FIELD_PROG 16'h0004

// Command word index values at launch.
`define FMDC_IDX_MARGIN 3'h1
`define FMDC_IDX_EVERIFY 3'h2
`define FMDC_IDX_PROG_MIN 3'h2
`define FMDC_IDX_PROG_MAX 3'h5
`define FMDC_IDX_FIRST_DATA 3'h2

// Array operation codes.
`define FMDC_OP_READ_ERASED 2'h0
`define FMDC_OP_PROGRAM 2'h1
`define FMDC_OP_READ_PROG 2'h2

`endif

// >>> verilog/fmdc_pkg.sv
package fmdc_pkg;

  typedef enum logic [1:0] {
    FMDC_S_IDLE = 2'b00,
    FMDC_S_CHECK = 2'b01,
    FMDC_S_REQ = 2'b10,
    FMDC_S_WAIT = 2'b11
  } fmdc_state_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } fmdc_bus_type;

  typedef struct packed {
    logic req;
    logic [1:0] op;
    logic [22:0] addr;
    logic [15:0] wdata;
  } fmdc_arr_req_type;

  typedef struct packed {
    logic ack;
    logic err;
    logic fatal;
  } fmdc_arr_rsp_type;

endpackage

// >>> verilog/fmdc_sequencer.sv
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`include "fmdc_params.svh"

// How it works
// - Field-margin command only runs in special modes.
// - Valid margin command sets block level, completes.
// - Margin codes zero to four select levels.
// - Margin command needs word index 001.
// - Undefined margin code raises access error.
// - Invalid block bits raise access error.
// - Command not allowed in mode: access error.
// - Erase-verify uses three parameter words.
// - Erase-verify needs word index 010.
// - Odd data-flash address raises access error.
// - Address outside data-flash raises access error.
// - Erase-verify range past block end: error.
// - Verify read errors set verify flags.
// - Erase-verify checks section then completes.
// - Program takes address then up to four words.
// - Word count follows index at launch.
// - Program index outside 010..101: access error.
// - Program words past block end: error.
// - Protected area: violation flag, nothing written.
// - Program verifies words, flags errors, completes.
// - Interrupt while complete flag and enable set.
module fmdc_sequencer #(
  parameter logic [6:0] DF_BLOCK = 7'h10,
  parameter logic [6:0] PF_BLOCK_LO = 7'h40,
  parameter logic [6:0] PF_BLOCK_HI = 7'h7f,
  parameter logic [15:0] DF_LAST = 16'h7fff
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire fmdc_pkg::fmdc_bus_type bus,
  output logic [15:0] rdata,
  input wire logic special_mode,
  output fmdc_pkg::fmdc_arr_req_type arr,
  input wire fmdc_pkg::fmdc_arr_rsp_type arr_rsp,
  output logic [2:0] df_margin,
  output logic [2:0] pf_margin,
  output logic cmd_irq
);
  import fmdc_pkg::*;

  typedef struct packed {
    fmdc_state_type st;
    logic command_complete_flag;
    logic access_error_flag;
    logic protection_violation_flag;
    logic mg1;
    logic mg0;
    logic command_complete_irq_enable;
    logic prot_en;
    logic [15:0] prot_start;
    logic [2:0] idx;
    logic [5:0][15:0] words;
    logic launch_special;
    logic verify;
    logic [15:0] rem;
    logic [2:0] wsel;
    logic [22:0] addr;
    logic [2:0] df_margin;
    logic [2:0] pf_margin;
    logic [15:0] rdata;
    fmdc_arr_req_type arr;
  } fmdc_core_type;

  fmdc_core_type r_reg;
  fmdc_core_type r_next;

  logic launch;
  logic [7:0] cmd;
  logic [6:0] blk;
  logic [22:0] gaddr;
  logic [23:0] ev_end;
  logic [23:0] pg_end;
  logic [23:0] df_last_full;
  logic blk_valid;
  logic margin_ok;
  logic df_in_range;
  logic err_margin;
  logic err_everify;
  logic err_program;
  logic prot_hit;

  assign cmd = r_reg.words[0][15:8];
  assign blk = r_reg.words[0][6:0];
  assign gaddr = {blk, r_reg.words[1]};
  assign df_last_full = {1'b0, DF_BLOCK, DF_LAST};
  assign launch = bus.wr && (bus.addr == `FMDC_OFF_STATUS) && bus.wdata[`FMDC_BIT_COMMAND_COMPLETE_FLAG]
    && r_reg.command_complete_flag && !r_reg.access_error_flag && !r_reg.protection_violation_flag;

  assign blk_valid = (blk == DF_BLOCK) || ((blk >= PF_BLOCK_LO) && (blk <= PF_BLOCK_HI));
  assign margin_ok = (r_reg.words[1] <= `FMDC_MARGIN_FIELD_PROG);
  assign df_in_range = (blk == DF_BLOCK) && (r_reg.words[1] <= DF_LAST);
  assign ev_end = {1'b0, gaddr} + {7'h00, r_reg.words[2], 1'b0} - 24'h000001;
  assign pg_end = {1'b0, gaddr} + {20'h00000, r_reg.idx - 3'h1, 1'b0} - 24'h000001;
  assign prot_hit = r_reg.prot_en && (pg_end[15:0] >= r_reg.prot_start);

  always_comb begin
    err_margin = !r_reg.launch_special;
    if (r_reg.idx != `FMDC_IDX_MARGIN) begin
      err_margin = 1'b1;
    end
    if (!margin_ok) begin
      err_margin = 1'b1;
    end
    if (!blk_valid) begin
      err_margin = 1'b1;
    end
    err_everify = (r_reg.idx != `FMDC_IDX_EVERIFY);
    err_program = (r_reg.idx < `FMDC_IDX_PROG_MIN) || (r_reg.idx > `FMDC_IDX_PROG_MAX);
    if (gaddr[0] || !df_in_range) begin
      err_everify = 1'b1;
      err_program = 1'b1;
    end
    if (ev_end > df_last_full) begin
      err_everify = 1'b1;
    end
    if (pg_end > df_last_full) begin
      err_program = 1'b1;
    end
  end

  always_comb begin
    r_next = r_reg;
    r_next.rdata = 16'h0000;
    if (bus.rd) begin
      case (bus.addr)
        `FMDC_OFF_STATUS: begin
          r_next.rdata = {8'h00, r_reg.command_complete_flag, 1'b0, r_reg.access_error_flag, r_reg.protection_violation_flag,
            2'b00, r_reg.mg1, r_reg.mg0};
        end
        `FMDC_OFF_CONFIG: begin
          r_next.rdata = {8'h00, r_reg.command_complete_irq_enable, 6'h00, r_reg.prot_en};
        end
        `FMDC_OFF_INDEX: begin
          r_next.rdata = {13'h0000, r_reg.idx};
        end
        `FMDC_OFF_WORD: begin
          r_next.rdata = (r_reg.idx <= 3'h5) ? r_reg.words[r_reg.idx] : 16'h0000;
        end
        `FMDC_OFF_MARGIN: begin
          r_next.rdata = {10'h000, r_reg.pf_margin, r_reg.df_margin};
        end
        `FMDC_OFF_PROTECT: begin
          r_next.rdata = r_reg.prot_start;
        end
        default: begin
          r_next.rdata = 16'h0000;
        end
      endcase
    end
    if (bus.wr) begin
      case (bus.addr)
        `FMDC_OFF_STATUS: begin
          if (bus.wdata[`FMDC_BIT_ACCESS_ERROR_FLAG]) begin
            r_next.access_error_flag = 1'b0;
          end
          if (bus.wdata[`FMDC_BIT_PROTECTION_VIOLATION_FLAG]) begin
            r_next.protection_violation_flag = 1'b0;
          end
        end
        `FMDC_OFF_CONFIG: begin
          r_next.command_complete_irq_enable = bus.wdata[`FMDC_BIT_COMMAND_COMPLETE_IRQ_ENABLE];
          r_next.prot_en = bus.wdata[`FMDC_BIT_PROT_EN];
        end
        `FMDC_OFF_INDEX: begin
          if (r_reg.command_complete_flag) begin
            r_next.idx = bus.wdata[2:0];
          end
        end
        `FMDC_OFF_WORD: begin
          if (r_reg.command_complete_flag && (r_reg.idx <= 3'h5)) begin
            r_next.words[r_reg.idx] = bus.wdata;
          end
        end
        `FMDC_OFF_PROTECT: begin
          r_next.prot_start = bus.wdata;
        end
        default: begin
        end
      endcase
    end
    if (launch) begin
      r_next.command_complete_flag = 1'b0;
      r_next.mg1 = 1'b0;
      r_next.mg0 = 1'b0;
      r_next.launch_special = special_mode;
      r_next.st = FMDC_S_CHECK;
    end
    case (r_reg.st)
      FMDC_S_IDLE: begin
      end
      FMDC_S_CHECK: begin
        r_next.addr = gaddr;
        r_next.wsel = 3'h0;
        r_next.st = FMDC_S_IDLE;
        r_next.command_complete_flag = 1'b1;
        case (cmd)
          `FMDC_CMD_FIELD_MARGIN: begin
            if (err_margin) begin
              r_next.access_error_flag = 1'b1;
            end else if (blk == DF_BLOCK) begin
              r_next.df_margin = r_reg.words[1][2:0];
            end else begin
              r_next.pf_margin = r_reg.words[1][2:0];
            end
          end
          `FMDC_CMD_ERASE_VERIFY: begin
            if (err_everify) begin
              r_next.access_error_flag = 1'b1;
            end else begin
              r_next.verify = 1'b1;
              r_next.rem = r_reg.words[2];
              r_next.command_complete_flag = 1'b0;
              r_next.st = FMDC_S_REQ;
            end
          end
          `FMDC_CMD_PROGRAM: begin
            if (err_program) begin
              r_next.access_error_flag = 1'b1;
            end else if (prot_hit) begin
              r_next.protection_violation_flag = 1'b1;
            end else begin
              r_next.verify = 1'b0;
              r_next.rem = {13'h0000, r_reg.idx - 3'h1};
              r_next.command_complete_flag = 1'b0;
              r_next.st = FMDC_S_REQ;
            end
          end
          default: begin
            r_next.access_error_flag = 1'b1;
          end
        endcase
      end
      FMDC_S_REQ: begin
        if (r_reg.rem != 16'h0000) begin
          r_next.arr.req = 1'b1;
          r_next.arr.addr = r_reg.addr;
          r_next.arr.wdata = r_reg.words[`FMDC_IDX_FIRST_DATA + r_reg.wsel];
          if (!r_reg.verify) begin
            r_next.arr.op = `FMDC_OP_PROGRAM;
          end else if (cmd == `FMDC_CMD_PROGRAM) begin
            r_next.arr.op = `FMDC_OP_READ_PROG;
          end else begin
            r_next.arr.op = `FMDC_OP_READ_ERASED;
          end
          r_next.st = FMDC_S_WAIT;
        end else if (!r_reg.verify) begin
          r_next.verify = 1'b1;
          r_next.addr = gaddr;
          r_next.wsel = 3'h0;
          r_next.rem = {13'h0000, r_reg.idx - 3'h1};
        end else begin
          r_next.command_complete_flag = 1'b1;
          r_next.st = FMDC_S_IDLE;
        end
      end
      FMDC_S_WAIT: begin
        if (arr_rsp.ack) begin
          r_next.arr.req = 1'b0;
          if (r_reg.verify && (arr_rsp.err || arr_rsp.fatal)) begin
            r_next.mg1 = 1'b1;
          end
          if (r_reg.verify && arr_rsp.fatal) begin
            r_next.mg0 = 1'b1;
          end
          r_next.addr = r_reg.addr + 23'h000002;
          r_next.wsel = r_reg.wsel + 3'h1;
          r_next.rem = r_reg.rem - 16'h0001;
          r_next.st = FMDC_S_REQ;
        end
      end
      default: begin
        r_next.st = FMDC_S_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      r_reg <= '0;
      r_reg.command_complete_flag <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign rdata = r_reg.rdata;
  assign arr = r_reg.arr;
  assign df_margin = r_reg.df_margin;
  assign pf_margin = r_reg.pf_margin;
  assign cmd_irq = r_reg.command_complete_flag && r_reg.command_complete_irq_enable;

  a_margin_mode: assert property (@(posedge ref_clk) disable iff (srst)
    (launch && cmd == `FMDC_CMD_FIELD_MARGIN && !special_mode)
      |=> ##1 (r_reg.access_error_flag && r_reg.command_complete_flag && $stable(r_reg.df_margin)))
    else $error("Margin command ran outside special mode.");

  a_margin_apply: assert property (@(posedge ref_clk) disable iff (srst)
    (r_reg.st == FMDC_S_CHECK && cmd == `FMDC_CMD_FIELD_MARGIN && !err_margin
      && blk == DF_BLOCK) |=> (r_reg.command_complete_flag && r_reg.df_margin == $past(r_reg.words[1][2:0])))
    else $error("Margin level was not applied.");

  a_margin_index: assert property (@(posedge ref_clk) disable iff (srst)
    (r_reg.st == FMDC_S_CHECK && cmd == `FMDC_CMD_FIELD_MARGIN
      && r_reg.idx != `FMDC_IDX_MARGIN) |=> r_reg.access_error_flag)
    else $error("Bad margin index not flagged.");

  a_margin_code: assert property (@(posedge ref_clk) disable iff (srst)
    (r_reg.st == FMDC_S_CHECK && cmd == `FMDC_CMD_FIELD_MARGIN
      && r_reg.words[1] > 16'h0004) |=> (r_reg.access_error_flag && r_reg.command_complete_flag))
    else $error("Bad margin code not flagged.");

  a_odd_address: assert property (@(posedge ref_clk) disable iff (srst)
    (r_reg.st == FMDC_S_CHECK && cmd == `FMDC_CMD_PROGRAM && gaddr[0])
      |=> (r_reg.access_error_flag && r_reg.st == FMDC_S_IDLE && !r_reg.arr.req))
    else $error("Odd address started a program.");

  a_ev_index: assert property (@(posedge ref_clk) disable iff (srst)
    (r_reg.st == FMDC_S_CHECK && cmd == `FMDC_CMD_ERASE_VERIFY
      && r_reg.idx != `FMDC_IDX_EVERIFY) |=> (r_reg.access_error_flag && r_reg.command_complete_flag))
    else $error("Erase verify index error missed.");

  a_prog_index: assert property (@(posedge ref_clk) disable iff (srst)
    (r_reg.st == FMDC_S_CHECK && cmd == `FMDC_CMD_PROGRAM && r_reg.idx > 3'h5)
      |=> r_reg.access_error_flag)
    else $error("Program index error missed.");

  a_prot_nowrite: assert property (@(posedge ref_clk) disable iff (srst)
    (r_reg.st == FMDC_S_CHECK && cmd == `FMDC_CMD_PROGRAM && !err_program && prot_hit)
      |=> (r_reg.protection_violation_flag && r_reg.command_complete_flag) ##1 !r_reg.arr.req)
    else $error("Protected area was programmed.");

  a_verify_fatal: assert property (@(posedge ref_clk) disable iff (srst)
    (r_reg.st == FMDC_S_WAIT && r_reg.verify && arr_rsp.ack && arr_rsp.fatal)
      |=> (r_reg.mg0 && r_reg.mg1))
    else $error("Fatal read error not flagged.");

  a_launch_busy: assert property (@(posedge ref_clk) disable iff (srst)
    launch |=> (!r_reg.command_complete_flag && r_reg.st == FMDC_S_CHECK))
    else $error("Launch did not clear the complete flag.");

  a_block_check: assert property (@(posedge ref_clk) disable iff (srst)
    (r_reg.st == FMDC_S_CHECK && cmd == `FMDC_CMD_FIELD_MARGIN && !blk_valid)
      |=> (r_reg.access_error_flag && $stable(r_reg.pf_margin)))
    else $error("Invalid block not flagged.");

  a_df_range: assert property (@(posedge ref_clk) disable iff (srst)
    (r_reg.st == FMDC_S_CHECK && cmd == `FMDC_CMD_ERASE_VERIFY && !df_in_range)
      |=> (r_reg.access_error_flag && r_reg.st == FMDC_S_IDLE))
    else $error("Address outside data flash not flagged.");

  a_ev_range: assert property (@(posedge ref_clk) disable iff (srst)
    (r_reg.st == FMDC_S_CHECK && cmd == `FMDC_CMD_ERASE_VERIFY && ev_end > df_last_full)
      |=> (r_reg.access_error_flag && !r_reg.arr.req))
    else $error("Verify range past block end not flagged.");

  a_prog_range: assert property (@(posedge ref_clk) disable iff (srst)
    (r_reg.st == FMDC_S_CHECK && cmd == `FMDC_CMD_PROGRAM && pg_end > df_last_full)
      |=> (r_reg.access_error_flag && r_reg.st == FMDC_S_IDLE))
    else $error("Program range past block end not flagged.");

  a_unknown_op: assert property (@(posedge ref_clk) disable iff (srst)
    (r_reg.st == FMDC_S_CHECK && cmd != `FMDC_CMD_FIELD_MARGIN
      && cmd != `FMDC_CMD_ERASE_VERIFY && cmd != `FMDC_CMD_PROGRAM)
      |=> (r_reg.access_error_flag && r_reg.command_complete_flag))
    else $error("Unknown command not flagged.");

  a_verify_err: assert property (@(posedge ref_clk) disable iff (srst)
    (r_reg.st == FMDC_S_WAIT && r_reg.verify && arr_rsp.ack && arr_rsp.err)
      |=> r_reg.mg1)
    else $error("Verify read error not flagged.");

  a_ev_done: assert property (@(posedge ref_clk) disable iff (srst)
    (r_reg.st == FMDC_S_REQ && r_reg.verify && r_reg.rem == 16'h0000)
      |=> (r_reg.command_complete_flag && r_reg.st == FMDC_S_IDLE))
    else $error("Verify end did not complete.");

endmodule // fmdc_sequencer

// >>> tb/fmdc_testbench.sv
`timescale 1ns/1ns
`include "fmdc_params.svh"
module testbench;
  import fmdc_pkg::*;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  fmdc_bus_type bus = '0;
  logic [15:0] rdata;
  logic special_mode = 1'b0;
  fmdc_arr_req_type arr;
  fmdc_arr_rsp_type arr_rsp = '0;
  logic [2:0] df_margin;
  logic [2:0] pf_margin;
  logic cmd_irq;
  int fails = 0;
  int tests_run = 0;
  logic [31:0] seed = 32'h7d8e;
  logic [15:0] w [6];
  logic [15:0] rd_val;
  logic [15:0] prot_start = 16'hffff;
  logic prot_en = 1'b0;
  logic irq_en = 1'b0;
  logic [1:0] inj = 2'b00;
  logic [2:0] exp_df = 3'h0;
  logic [2:0] exp_pf = 3'h0;
  logic [3:0] wait_cnt = 4'h0;
  logic [40:0] log_q [$];

  fmdc_sequencer u_dut (.ref_clk(ref_clk), .srst(srst), .bus(bus), .rdata(rdata),
    .special_mode(special_mode), .arr(arr), .arr_rsp(arr_rsp), .df_margin(df_margin),
    .pf_margin(pf_margin), .cmd_irq(cmd_irq));

  always #50 ref_clk = ~ref_clk;

  // The array answers after a varying delay and logs every request it ends.
  always @(posedge ref_clk) begin
    if (arr_rsp.ack) begin
      arr_rsp <= '0;
    end else if (arr.req && wait_cnt == 4'h0) begin
      arr_rsp.ack <= 1'b1;
      arr_rsp.err <= inj[1] && arr.op != `FMDC_OP_PROGRAM;
      arr_rsp.fatal <= inj[0] && arr.op != `FMDC_OP_PROGRAM;
      log_q.push_back({arr.op, arr.addr, arr.wdata});
      wait_cnt <= arr.addr[4:1] ^ arr.wdata[3:0];
    end else if (arr.req) begin
      wait_cnt <= wait_cnt - 4'h1;
    end
  end

  function logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  // Expected {access error, protection violation} for the loaded words.
  function automatic logic [1:0] exp_flags(input logic [2:0] idx);
    logic [6:0] b;
    int a;
    int last;
    b = w[0][6:0];
    a = int'(w[1]);
    last = 0;
    case (w[0][15:8])
      `FMDC_CMD_FIELD_MARGIN: begin
        return {!special_mode || idx != 3'h1 || w[1] > 16'h4 || (b != 7'h10 && b < 7'h40), 1'b0};
      end
      `FMDC_CMD_ERASE_VERIFY: begin
        if (idx != 3'h2) return 2'b10;
        last = a + 2 * int'(w[2]) - 1;
      end
      `FMDC_CMD_PROGRAM: begin
        if (idx < 3'h2 || idx > 3'h5) return 2'b10;
        last = a + 2 * int'(idx) - 3;
      end
      default: return 2'b10;
    endcase
    if (w[1][0] || b != 7'h10 || a > 32767 || last > 32767) return 2'b10;
    return {1'b0, w[0][15:8] == `FMDC_CMD_PROGRAM && prot_en && last[15:0] >= prot_start};
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_req(input logic [40:0] got, input logic [40:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: array request %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    @(negedge ref_clk);
    rd_val = rdata;
  endtask

  task automatic mode(input logic m);
    @(posedge ref_clk);
    special_mode <= m;
  endtask

  task automatic tend(input string name);
    $display("test %s done", name);
  endtask

  // Loads all words, launches, waits for completion and checks every result.
  task automatic cmd(input logic [7:0] op, input logic [6:0] b, input logic [15:0] a,
      input logic [15:0] c, input logic [2:0] idx);
    logic [31:0] r;
    logic [1:0] ef;
    logic [40:0] e;
    logic [40:0] m;
    int k;
    int n;
    int nw;
    r = rnd();
    w = '{{op, 1'b0, b}, a, c, r[15:0], r[31:16], r[23:8]};
    log_q.delete();
    for (k = 0; k < 6; k++) begin
      wr(`FMDC_OFF_INDEX, 16'(k));
      wr(`FMDC_OFF_WORD, w[k]);
    end
    wr(`FMDC_OFF_INDEX, {13'h0, idx});
    wr(`FMDC_OFF_CONFIG, {8'h0, irq_en, 6'h0, prot_en});
    wr(`FMDC_OFF_PROTECT, prot_start);
    wr(`FMDC_OFF_STATUS, 16'h0030);
    ef = exp_flags(idx);
    wr(`FMDC_OFF_STATUS, 16'h0080);
    rd_val = 16'h0;
    for (k = 0; k < 150 && !rd_val[7]; k++) rd(`FMDC_OFF_STATUS);
    nw = int'(idx) - 1;
    n = 0;
    if (ef == 2'b00 && op == `FMDC_CMD_PROGRAM) n = 2 * nw;
    if (ef == 2'b00 && op == `FMDC_CMD_ERASE_VERIFY) n = int'(c);
    chk(rd_val, {8'h0, 1'b1, 1'b0, ef, 2'b00, (n > 0) ? inj : 2'b00}, "status");
    chk(16'(log_q.size()), 16'(n), "array count");
    m = (op == `FMDC_CMD_PROGRAM) ? '1 : {25'h1ffffff, 16'h0};
    for (k = 0; k < n && k < log_q.size(); k++) begin
      if (op == `FMDC_CMD_PROGRAM) begin
        e = {(k < nw) ? `FMDC_OP_PROGRAM : `FMDC_OP_READ_PROG, b, a + 16'(2 * (k % nw)),
          w[2 + k % nw]};
      end else begin
        e = {`FMDC_OP_READ_ERASED, b, a + 16'(2 * k), 16'h0};
      end
      chk_req(log_q[k] & m, e);
    end
    if (ef == 2'b00 && op == `FMDC_CMD_FIELD_MARGIN) begin
      if (b == 7'h10) exp_df = a[2:0];
      else exp_pf = a[2:0];
    end
    rd(`FMDC_OFF_MARGIN);
    chk(rd_val, {10'h0, exp_pf, exp_df}, "margin reg");
    chk({10'h0, pf_margin, df_margin}, {10'h0, exp_pf, exp_df}, "margin out");
    chk({15'h0, cmd_irq}, {15'h0, irq_en}, "irq");
  endtask

  task automatic tally_and_finish();
    $display("tests_run %0d fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #(9_000_000);
    fails++;
    $display("Error at %0t: watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    int i;
    logic [31:0] r;
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    rd(`FMDC_OFF_STATUS);
    chk(rd_val, 16'h0080, "reset status");
    rd(8'h20);
    chk(rd_val, 16'h0000, "unmapped");
    tend("reset");
    mode(1'b1);
    for (i = 0; i < 6; i++) begin
      cmd(8'h0e, 7'h10, 16'(i), 16'h0, 3'h1);
      cmd(8'h0e, 7'h7f, 16'(5 - i), 16'h0, 3'h1);
    end
    cmd(8'h0e, 7'h40, 16'h4, 16'h0, 3'h0);
    cmd(8'h0e, 7'h40, 16'h3, 16'h0, 3'h2);
    cmd(8'h0e, 7'h3f, 16'h1, 16'h0, 3'h1);
    mode(1'b0);
    cmd(8'h0e, 7'h10, 16'h2, 16'h0, 3'h1);
    tend("margin");
    cmd(8'h10, 7'h10, 16'h0100, 16'h3, 3'h2);
    cmd(8'h10, 7'h10, 16'h0100, 16'h3, 3'h3);
    cmd(8'h10, 7'h10, 16'h0101, 16'h1, 3'h2);
    cmd(8'h10, 7'h11, 16'h0100, 16'h1, 3'h2);
    cmd(8'h10, 7'h10, 16'h8000, 16'h0, 3'h2);
    cmd(8'h10, 7'h10, 16'h7ffe, 16'h1, 3'h2);
    cmd(8'h10, 7'h10, 16'h7ffe, 16'h2, 3'h2);
    cmd(8'h10, 7'h10, 16'h0000, 16'h0, 3'h2);
    inj = 2'b10;
    cmd(8'h10, 7'h10, 16'h0200, 16'h2, 3'h2);
    inj = 2'b11;
    cmd(8'h10, 7'h10, 16'h0400, 16'h1, 3'h2);
    inj = 2'b00;
    tend("verify");
    for (i = 2; i < 6; i++) cmd(8'h11, 7'h10, 16'h0100, 16'h5a3c, 3'(i));
    cmd(8'h11, 7'h10, 16'h0100, 16'h1234, 3'h1);
    cmd(8'h11, 7'h10, 16'h0100, 16'h1234, 3'h6);
    cmd(8'h11, 7'h10, 16'h7ff8, 16'h00ff, 3'h5);
    cmd(8'h11, 7'h10, 16'h7ffa, 16'h00ff, 3'h5);
    cmd(8'h11, 7'h10, 16'h0103, 16'h00ff, 3'h2);
    prot_en = 1'b1;
    prot_start = 16'h0104;
    cmd(8'h11, 7'h10, 16'h0100, 16'h0f0f, 3'h3);
    cmd(8'h11, 7'h10, 16'h0100, 16'h0f0f, 3'h4);
    prot_en = 1'b0;
    inj = 2'b11;
    irq_en = 1'b1;
    cmd(8'h11, 7'h10, 16'h0300, 16'ha5a5, 3'h4);
    inj = 2'b00;
    cmd(8'h22, 7'h10, 16'h0000, 16'h0, 3'h2);
    tend("program");
    for (i = 0; i < 40; i++) begin
      r = rnd();
      mode(r[0]);
      prot_en = r[1];
      prot_start = {1'b0, r[31:17]};
      irq_en = r[2];
      inj = {r[3], r[3] & r[4]};
      cmd(r[6] ? (r[5] ? 8'h11 : 8'h10) : (r[5] ? 8'h0e : r[14:7]), r[8] ? 7'h10 : r[15:9],
        {r[31] & r[30], r[29:16], r[12] & r[13]}, {13'h0, r[19:17]}, r[22:20]);
    end
    tend("random");
    tally_and_finish();
  end
endmodule // testbench
